// File: inc/ubb_pkg.sv
// Purpose: shared constants and types for the bit-bang channel block
// Assumes: one channel per instance of the top module
// Notes: mode codes are the values carried by the mode-set command
package ubb_pkg;
	localparam int UBB_W = 8;
	localparam logic [7:0] UBB_MODE_RESET = 8'h00;
	localparam logic [7:0] UBB_MODE_ASYNC = 8'h01;
	localparam logic [7:0] UBB_MODE_SERIAL = 8'h02;
	localparam logic [7:0] UBB_MODE_SYNC = 8'h04;
	localparam logic [7:0] UBB_DIR_RESET = 8'h00;
	localparam logic [7:0] UBB_PINS_RESET = 8'h00;
	localparam int UBB_SYNC_STAGES = 2;
	// setup time between pin update and next sample, in clock cycles
	localparam int UBB_SETUP_CYC = 1;
	localparam int UBB_SERIAL_CHANNELS = 2;
	localparam logic [1:0] UBB_CH_FIRST = 2'h0;
	typedef enum {UBB_UART, UBB_ASYNC, UBB_SYNC, UBB_SERIAL} ubb_mode_t;
	typedef enum {UBB_IDLE, UBB_SAMPLE, UBB_SEND, UBB_DRIVE, UBB_SETUP} ubb_state_t;
endpackage

// File: rtl/ubb_sync.sv
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module ubb_sync #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: rtl/ubb_channel.sv
// Purpose: one channel of the bit-bang engine with mode selection
// Assumes: byte streams from/to the USB fifos use valid/ready; baud tick from a divider
// Notes: the serial engine itself lives elsewhere; only its enable and adaptive clock hold
//
// Summary of operation
// - adaptive clock: hold data until returned clock
// - adaptive clocking off until host enables it
// - async mode drives written byte onto outputs
// - per-pin direction register
// - async outputs change only on baud tick
// - outputs hold last value without new byte
// - sync mode updates pins per received byte
// - sync mode takes one pin sample per written byte
// - sync waits for transmit fifo room
// - sample before drive, readback lags one byte
// - mode value one selects async bit-bang
// - mode value four selects sync bit-bang
// - sample, forward, drive, one setup cycle
// - no write or read strobes in bit-bang
// - reset returns channel to uart mode
// - config memory only gates rs485 enable
// - each channel keeps its own mode
// - bit-bang modes available on every channel
// - value two serial engine, zero resets
// - serial engine only on first two channels
`timescale 1ns/1ns
`default_nettype none
module ubb_channel
	import ubb_pkg::*;
#(
	parameter logic [1:0] CHANNEL = 2'h0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// mode-set command
	input wire logic mode_set_command_i,
	input wire logic [7:0] mode_value_i,
	input wire logic [7:0] dir_mask_i,
	input wire logic adaptive_en_set_i,
	input wire logic adaptive_en_value_i,
	// baud-rate clock tick
	input wire logic baud_tick_i,
	// from usb receive fifo
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// to usb transmit fifo
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// parallel pins
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o,
	// serial engine adaptive clock interface
	input wire logic serial_clk_drive_i,
	input wire logic low_gpio_line_three_i,
	output logic serial_data_hold_o,
	// status
	output logic [1:0] mode_o,
	output logic serial_en_o,
	output logic adaptive_en_o,
	// uart side
	input wire logic cfg_rs485_i,
	input wire logic uart_tx_busy_i,
	output logic rs485_transmit_enable_o,
	output logic write_strobe_n_o,
	output logic read_strobe_n_o
);
	// ******************************
	// pin synchronisers
	// ******************************
	logic [7:0] pin_s;
	logic [0:0] ret_clk_s;
	ubb_sync #(.W(UBB_W)) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(pin_i),
		.q_o(pin_s)
	);
	ubb_sync #(.W(1)) u_ret_clk_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(low_gpio_line_three_i),
		.q_o(ret_clk_s)
	);

	// ******************************
	// mode selection
	// ******************************
	ubb_mode_t mode_r;
	logic serial_ok;
	logic mode_chg;
	assign serial_ok = (CHANNEL < 2'(UBB_SERIAL_CHANNELS));
	// a new mode-set resets the pipeline even when the value is unchanged
	assign mode_chg = mode_set_command_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= UBB_UART;
		end else if (mode_set_command_i) begin
			// mode lives per instance, so channels are independent
			if (mode_value_i == UBB_MODE_ASYNC) begin
				mode_r <= UBB_ASYNC;
			end else if (mode_value_i == UBB_MODE_SYNC) begin
				mode_r <= UBB_SYNC;
			end else if (mode_value_i == UBB_MODE_SERIAL) begin
				if (serial_ok) begin
					mode_r <= UBB_SERIAL;
				end
			end else if (mode_value_i == UBB_MODE_RESET) begin
				mode_r <= UBB_UART;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_oe_o <= UBB_DIR_RESET;
		end else if (mode_set_command_i) begin
			pin_oe_o <= dir_mask_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_o <= 2'h0;
			serial_en_o <= 1'b0;
		end else begin
			case (mode_r)
				UBB_ASYNC: mode_o <= 2'h1;
				UBB_SYNC: mode_o <= 2'h2;
				UBB_SERIAL: mode_o <= 2'h3;
				default: mode_o <= 2'h0;
			endcase
			serial_en_o <= (mode_r == UBB_SERIAL);
		end
	end

	// ******************************
	// adaptive clocking
	// ******************************
	logic adapt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adapt_r <= 1'b0;
		end else if (adaptive_en_set_i && serial_ok) begin
			adapt_r <= adaptive_en_value_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adaptive_en_o <= 1'b0;
			serial_data_hold_o <= 1'b0;
		end else begin
			adaptive_en_o <= adapt_r;
			// hold data while clock driven but returned clock not yet seen
			serial_data_hold_o <= adapt_r && (mode_r == UBB_SERIAL) &&
				serial_clk_drive_i && !ret_clk_s[0];
		end
	end

	// ******************************
	// bit-bang datapath
	// ******************************
	ubb_state_t st_r;
	logic [7:0] byte_r;
	logic [7:0] samp_r;
	logic take;
	// sync mode only accepts a byte when the transmit fifo is ready and no sample is pending
	assign take = rx_valid_i && rx_ready_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_ready_o <= 1'b0;
		end else begin
			rx_ready_o <= !mode_chg && !rx_ready_o && !rx_valid_i ? 1'b0 :
				(!mode_chg && (st_r == UBB_IDLE) && !take &&
				((mode_r == UBB_ASYNC) || ((mode_r == UBB_SYNC) && tx_ready_i &&
				!tx_valid_o)));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || mode_chg) begin
			st_r <= UBB_IDLE;
			byte_r <= UBB_PINS_RESET;
		end else begin
			case (st_r)
				UBB_IDLE: begin
					if (take) begin
						byte_r <= rx_data_i;
						st_r <= (mode_r == UBB_SYNC) ? UBB_SAMPLE : UBB_DRIVE;
					end
				end
				UBB_SAMPLE: st_r <= UBB_SEND;
				UBB_SEND: st_r <= UBB_DRIVE;
				UBB_DRIVE: begin
					if (mode_r == UBB_SYNC) begin
						st_r <= UBB_SETUP;
					end else if (baud_tick_i) begin
						st_r <= UBB_IDLE;
					end
				end
				UBB_SETUP: st_r <= UBB_IDLE;
				default: st_r <= UBB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_r <= UBB_PINS_RESET;
		end else if (st_r == UBB_SAMPLE) begin
			samp_r <= pin_s;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || mode_chg) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= UBB_PINS_RESET;
		end else if (st_r == UBB_SEND) begin
			tx_valid_o <= 1'b1;
			tx_data_o <= samp_r;
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= UBB_PINS_RESET;
		end else if (st_r == UBB_DRIVE) begin
			if (mode_r == UBB_SYNC || baud_tick_i) begin
				pin_o <= byte_r;
			end
		end
		// otherwise last value is held
	end

	// ******************************
	// strobes and rs485 enable
	// ******************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_strobe_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			rs485_transmit_enable_o <= 1'b0;
		end else begin
			write_strobe_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			// config memory never touches mode_r
			rs485_transmit_enable_o <= cfg_rs485_i && (mode_r == UBB_UART) && uart_tx_busy_i;
		end
	end
endmodule
`default_nettype wire

// File: verification/ubb_channel_chk.sv
// Purpose: port checks for one bit-bang channel
// Assumes: mode_o 1 async, 2 sync
// Notes: bound to every ubb_channel
`timescale 1ns/1ns
`default_nettype none
module ubb_channel_chk #(
	parameter logic [1:0] CHANNEL = 2'h0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mode_set_command_i,
	input wire logic adaptive_en_set_i,
	input wire logic adaptive_en_value_i,
	input wire logic baud_tick_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_ready_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_o,
	input wire logic [1:0] mode_o,
	input wire logic adaptive_en_o,
	input wire logic write_strobe_n_o,
	input wire logic read_strobe_n_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ****
	// checks
	// ****
	sequence take_s;
		mode_o == 2'h2 && rx_valid_i && rx_ready_o && !mode_set_command_i;
	endsequence
	strobe_idle_a: assert property (write_strobe_n_o && read_strobe_n_o)
		else $error("strobe driven");
	reset_state_a: assert property ($past(rst_i) |-> mode_o == 2'h0 &&
		pin_oe_o == 8'h00 && !adaptive_en_o) else $error("bad reset state");
	rx_busy_a: assert property (take_s |-> ##2 !rx_ready_o [*3])
		else $error("taken while busy");
	sync_walk_a: assert property (take_s ##1 !mode_set_command_i [*3] |=>
		$past(tx_valid_o) && pin_o == $past(rx_data_i, 4)) else $error("sync timing");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i && !mode_set_command_i |=>
		tx_valid_o && $stable(tx_data_o)) else $error("sample lost");
	pend_block_a: assert property (tx_valid_o |-> !rx_ready_o)
		else $error("ready while pending");
	async_tick_a: assert property (mode_o == 2'h1 && $past(mode_o) == 2'h1 &&
		$changed(pin_o) |-> $past(baud_tick_i)) else $error("pins moved untimed");
	adapt_rise_a: assert property ($rose(adaptive_en_o) |-> CHANNEL < 2'h2 &&
		$past(adaptive_en_set_i, 2) && $past(adaptive_en_value_i, 2)) else $error("adaptive unasked");
	cover property (take_s);
	cover property (mode_o == 2'h1 && $changed(pin_o));
	cover property ($rose(adaptive_en_o));
endmodule
bind ubb_channel ubb_channel_chk #(.CHANNEL(CHANNEL)) chk (.*);
`default_nettype wire

// File: verification/ubb_target.sv
// Purpose: target circuitry on the parallel pins
// Assumes: outputs loop back, inputs come from ext_i
// Notes: a slow target, clock returns three cycles late
`timescale 1ns/1ns
`default_nettype none
module ubb_target (
	input wire logic clk_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_o,
	input wire logic [7:0] ext_i,
	input wire logic sclk_i,
	output logic [7:0] pin_i,
	output logic ret_clk_o
);
	logic [2:0] dly_r = 3'h0;
	assign pin_i = (pin_o & pin_oe_o) | (ext_i & ~pin_oe_o);
	always_ff @(posedge clk_i) begin
		dly_r <= {dly_r[1:0], sclk_i};
	end
	assign ret_clk_o = dly_r[2];
endmodule
`default_nettype wire

// File: verification/ubb_channel_tb.sv
// Purpose: self-checking bench for one channel
// Assumes: 125 MHz clock, sync reset
// Notes: pins loop back through the target model
`timescale 1ns/1ns
`default_nettype none
module ubb_channel_tb;
	import ubb_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, ms = 1'b0, ae_set = 1'b0, ae_val = 1'b0, tick = 1'b0;
	logic rxv = 1'b0, txr = 1'b1, sclk = 1'b0, cfg = 1'b0, busy = 1'b0;
	logic rxr, txv, hold, sen, aen, rs485, wsn, rsn, rclk;
	logic [7:0] mv = 8'h00, dm = 8'h00, rxd = 8'h00, ext = 8'ha0, txd, pi, po, poe;
	logic [1:0] mo;
	int miscompares = 0, checked = 0;
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	ubb_channel DUT (.clk_i(clk_i), .rst_i(rst_i), .mode_set_command_i(ms), .mode_value_i(mv),
		.dir_mask_i(dm), .adaptive_en_set_i(ae_set), .adaptive_en_value_i(ae_val),
		.baud_tick_i(tick), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_ready_o(rxr), .tx_valid_o(txv),
		.tx_data_o(txd), .tx_ready_i(txr), .pin_i(pi), .pin_o(po), .pin_oe_o(poe),
		.serial_clk_drive_i(sclk), .low_gpio_line_three_i(rclk), .serial_data_hold_o(hold),
		.mode_o(mo), .serial_en_o(sen), .adaptive_en_o(aen), .cfg_rs485_i(cfg),
		.uart_tx_busy_i(busy), .rs485_transmit_enable_o(rs485), .write_strobe_n_o(wsn),
		.read_strobe_n_o(rsn));
	ubb_target tgt (.clk_i(clk_i), .pin_o(po), .pin_oe_o(poe), .ext_i(ext), .sclk_i(sclk),
		.pin_i(pi), .ret_clk_o(rclk));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic lim(input int n);
		if (n >= 50) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic setm(input logic [7:0] v, input logic [7:0] d);
		ms <= 1'b1;
		mv <= v;
		dm <= d;
		cyc(1);
		ms <= 1'b0;
		cyc(3);
	endtask
	task automatic put(input logic [7:0] b);
		int n = 0;
		rxv <= 1'b1;
		rxd <= b;
		do begin
			cyc(1);
			n++;
		end while (rxr !== 1'b1 && n < 50);
		rxv <= 1'b0;
		lim(n);
	endtask
	task automatic get(input logic [7:0] e);
		int n = 0;
		do begin
			cyc(1);
			n++;
		end while (txv !== 1'b1 && n < 50);
		lim(n);
		chk(txd, e);
	endtask
	task automatic t_reset();
		rst_i <= 1'b1;
		cyc(20);
		rst_i <= 1'b0;
		cyc(2);
		chk({6'h00, mo}, 8'h00);
		chk(poe, UBB_DIR_RESET);
		chk({7'h00, aen}, 8'h00);
	endtask
	task automatic t_async();
		setm(UBB_MODE_ASYNC, 8'hff);
		put(8'h3c);
		cyc(6);
		chk(po, UBB_PINS_RESET);
		tick <= 1'b1;
		cyc(1);
		tick <= 1'b0;
		cyc(2);
		chk(po, 8'h3c);
		cyc(20);
		chk(po, 8'h3c);
	endtask
	task automatic t_sync();
		setm(UBB_MODE_SYNC, 8'h0f);
		chk(poe, 8'h0f);
		txr <= 1'b0;
		rxv <= 1'b1;
		rxd <= 8'h55;
		cyc(8);
		chk({7'h00, rxr}, 8'h00);
		txr <= 1'b1;
		put(8'h55);
		get(8'hac);
		cyc(1);
		chk(po, 8'h55);
		put(8'haa);
		get(8'ha5);
		put(8'haa);
		get(8'haa);
	endtask
	task automatic t_mode();
		setm(8'h07, 8'h00);
		chk({6'h00, mo}, 8'h02);
		setm(UBB_MODE_SERIAL, 8'h00);
		chk({5'h00, mo, sen}, 8'h07);
		ae_set <= 1'b1;
		ae_val <= 1'b1;
		cyc(1);
		ae_set <= 1'b0;
		sclk <= 1'b1;
		cyc(2);
		chk({6'h00, aen, hold}, 8'h03);
		cyc(12);
		chk({7'h00, hold}, 8'h00);
		sclk <= 1'b0;
		setm(UBB_MODE_RESET, 8'h00);
		cfg <= 1'b1;
		busy <= 1'b1;
		cyc(3);
		chk({5'h00, mo, rs485}, 8'h01);
		chk({6'h00, wsn, rsn}, 8'h03);
	endtask
	initial begin
		t_reset();
		t_async();
		t_sync();
		t_mode();
		setm(UBB_MODE_SYNC, 8'hff);
		t_reset();
		setm(UBB_MODE_ASYNC, 8'h00);
		chk({6'h00, mo}, 8'h01);
		conclude();
	end
endmodule
`default_nettype wire
